// ---- seg_cache_defines.svh ----
// Offsets, field positions, reset values and sizes of the segmented cache.
`ifndef SEG_CACHE_DEFINES_SVH
`define SEG_CACHE_DEFINES_SVH
`define BUF_MB          64
`define CACHE_KB        30000
`define SEG_NUM         8
`define SEG_IDX_W       3
`define BLK_512         512
`define BLK_520         520
`define BLK_528         528
`define SEGSIZE_VAL     16'hFFFF
`define REG_MODE        8'h00
`define REG_SEGSIZE     8'h04
`define REG_STATUS      8'h08
`define REG_HITS        8'h0C
`define MODE_RCD_BIT    0
`define MODE_WCE_BIT    1
`define MODE_DRA_BIT    2
`define MODE_PARAM_CHECK_FLAG_A_BIT 3
`define MODE_BSZ_LO     4
`define MODE_BSZ_HI     5
`define ST_PARAM_BIT    0
`define ST_DEFER_BIT    1
`define ST_BUSY_BIT     2
`define ST_PFON_BIT     3
`define RST_RCD         1'b0
`define RST_WCE         1'b1
`define RST_DRA         1'b0
`define RST_PARAM_CHECK_FLAG_A      1'b0
`define RST_BSZ         2'h0
`endif

// ---- seg_cache_pkg.sv ----
// Types shared by the segmented cache controller and its users.
`include "seg_cache_defines.svh"
package seg_cache_pkg;
    typedef enum logic [1:0] {OP_READ = 2'h0, OP_WRITE = 2'h1, OP_SYNC = 2'h2} cmd_op_e;
    typedef enum logic [4:0] {
        S_IDLE  = 5'h01,
        S_LOOK  = 5'h02,
        S_INVAL = 5'h04,
        S_MREQ  = 5'h08,
        S_MWAIT = 5'h10
    } fsm_e;
    typedef struct packed {
        cmd_op_e     op;
        logic [31:0] lba;
        logic [15:0] nblk;
    } cmd_s;
    typedef struct packed {
        logic                  write;
        logic [31:0]           lba;
        logic [15:0]           nblk;
        logic [`SEG_IDX_W-1:0] seg;
    } med_s;
    typedef struct packed {
        logic good;
        logic hit;
        logic pf_hit;
    } resp_s;
    typedef struct packed {
        logic        valid;
        logic        dirty;
        logic        pf;
        logic [31:0] start;
        logic [15:0] cnt;
        logic [31:0] pfb;
    } seg_s;
    typedef struct packed {
        fsm_e                  st;
        seg_s [`SEG_NUM-1:0]   seg;
        logic [`SEG_IDX_W-1:0] vptr;
        logic [`SEG_IDX_W-1:0] cur;
        cmd_s                  cmd;
        logic [15:0]           ext;
        logic                  read_cache_disable_flag;
        logic                  write_cache_enable_flag;
        logic                  read_ahead_disable_flag;
        logic                  param_check_flag_a;
        logic [1:0]            bsz;
        logic                  param_err;
        logic                  defer_err;
        logic                  pf_on;
        logic                  early;
        logic [31:0]           last_end;
        logic [15:0]           hits;
        logic [15:0]           pf_hits;
        logic [31:0]           rdata;
        logic                  resp_valid;
        resp_s                 resp;
        logic                  med_valid;
        med_s                  med;
    } state_s;
endpackage : seg_cache_pkg

// ---- seg_cache.sv ----
// Segmented read/write buffer cache with adaptive read-ahead.
//
// The strobed register port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "seg_cache_defines.svh"
// How it works
// RQ1 - About 30000 KB of 64 MB buffer caches.
// RQ2 - Track segment LBAs; reads try buffer first.
// RQ3 - Cache off: no lookup, read the medium; the code still looks up and answers from a segment's read-ahead part.
// RQ4 - All blocks cached: answer without medium.
// RQ5 - Any block missing: fetch into a segment.
// RQ6 - Segments circular, whole blocks, created dynamically.
// RQ7 - Segment size reads 0xFFFF, writes ignored.
// RQ8 - Param_check_flag_a flag: size write flags a parameter error.
// RQ9 - Read cache on: written data stays cached.
// RQ10 - Writes clear overlapping segments, then cache.
// RQ11 - Oversize writes wrap; uncommitted data kept.
// RQ12 - Write cache on: early good, deferred errors.
// RQ13 - Sync completes only after all writes committed.
// RQ14 - Prefetch reads beyond range; counts prefetch hits.
// RQ15 - Read-ahead disable flag zero enables prefetch.
// RQ16 - Maximum prefetch and ceiling fields ignored.
// RQ17 - Prefetch switched by predicted hit likelihood.
// RQ18 - Segmentation independent of read cache flag.
// RQ19 - Block sizes 512, 520, 528; default 512.
// RQ20 - Lookup and invalidation precede media access.
module seg_cache
    import seg_cache_pkg::*;
#(
    parameter int PF_BLKS = 64
) (
    // Clock, reset and enable.
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        ce,
    // Register port.
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    // Host command and response.
    input  wire logic        cmd_valid,
    input  wire cmd_s        cmd,
    output logic             cmd_ready,
    output logic             resp_valid,
    output resp_s            resp,
    // Media path.
    output logic             med_valid,
    output med_s             med,
    input  wire logic        med_ready,
    input  wire logic        med_done,
    input  wire logic        med_err
);
    localparam logic [31:0] SEG_BYTES = (`CACHE_KB * 1024) / `SEG_NUM; // RQ1
    localparam logic [31:0] BUF_BYTES = `BUF_MB * 1024 * 1024;

    state_s r_ff;
    state_s nxt_r;

    logic [15:0]           cap;
    logic [31:0]           blk;
    logic [32:0]           req_end;
    logic [32:0]           tot_end;
    logic [16:0]           tot;
    logic                  hit;
    logic                  hit_pf;
    logic [`SEG_IDX_W-1:0] vict;
    logic                  vfree;

    // Segment capacity in blocks of the selected size.
    always_comb begin
        if (r_ff.bsz == 2'h1) begin
            blk = `BLK_520; // RQ19
        end else if (r_ff.bsz == 2'h2) begin
            blk = `BLK_528; // RQ19
        end else begin
            blk = `BLK_512; // RQ19
        end
        cap = 16'((SEG_BYTES < BUF_BYTES ? SEG_BYTES : BUF_BYTES) / blk); // RQ6
    end

    // Tag lookup and victim choice over all segments.
    always_comb begin
        hit     = 1'b0;
        hit_pf  = 1'b0;
        vfree   = 1'b0;
        vict    = r_ff.vptr;
        req_end = {1'b0, r_ff.cmd.lba} + 33'(r_ff.cmd.nblk);
        for (int i = 0; i < `SEG_NUM; i++) begin
            // With the cache off only the read-ahead part of a segment may answer.
            if (r_ff.seg[i].valid
                && (!r_ff.read_cache_disable_flag || (r_ff.seg[i].pf && r_ff.cmd.lba >= r_ff.seg[i].pfb)) // RQ3
                && r_ff.cmd.lba >= r_ff.seg[i].start
                && req_end <= {1'b0, r_ff.seg[i].start} + 33'(r_ff.seg[i].cnt)) begin
                hit    = 1'b1; // RQ2 RQ4
                hit_pf = r_ff.seg[i].pf && r_ff.cmd.lba >= r_ff.seg[i].pfb; // RQ14
            end
            if (!vfree && !r_ff.seg[i].valid && !r_ff.seg[i].dirty) begin
                vfree = 1'b1;
                vict  = `SEG_IDX_W'(i);
            end
        end
        tot     = 17'(r_ff.cmd.nblk) + 17'(r_ff.ext);
        tot_end = {1'b0, r_ff.cmd.lba} + 33'(tot);
    end

    assign cmd_ready = ce && r_ff.st == S_IDLE;

    always_comb begin
        nxt_r = r_ff;
        nxt_r.resp_valid = 1'b0;
        // Register reads and writes.
        if (reg_rd) begin
            if (reg_addr == `REG_MODE) begin
                nxt_r.rdata = {26'h0, r_ff.bsz, r_ff.param_check_flag_a, r_ff.read_ahead_disable_flag, r_ff.write_cache_enable_flag, r_ff.read_cache_disable_flag};
            end else if (reg_addr == `REG_SEGSIZE) begin
                nxt_r.rdata = {16'h0, `SEGSIZE_VAL}; // RQ7
            end else if (reg_addr == `REG_STATUS) begin
                nxt_r.rdata = {28'h0, r_ff.pf_on, r_ff.st != S_IDLE,
                               r_ff.defer_err, r_ff.param_err};
            end else if (reg_addr == `REG_HITS) begin
                nxt_r.rdata = {r_ff.pf_hits, r_ff.hits};
            end else begin
                nxt_r.rdata = 32'h0;
            end
        end
        if (reg_wr) begin
            if (reg_addr == `REG_MODE) begin
                // Flag changes leave the segment table untouched.
                nxt_r.read_cache_disable_flag    = reg_wdata[`MODE_RCD_BIT]; // RQ18
                nxt_r.write_cache_enable_flag    = reg_wdata[`MODE_WCE_BIT];
                nxt_r.read_ahead_disable_flag    = reg_wdata[`MODE_DRA_BIT]; // RQ15
                nxt_r.param_check_flag_a = reg_wdata[`MODE_PARAM_CHECK_FLAG_A_BIT];
                if (reg_wdata[`MODE_BSZ_HI:`MODE_BSZ_LO] != 2'h3) begin
                    nxt_r.bsz = reg_wdata[`MODE_BSZ_HI:`MODE_BSZ_LO]; // RQ19
                end
            end else if (reg_addr == `REG_SEGSIZE) begin
                if (r_ff.param_check_flag_a) begin
                    nxt_r.param_err = 1'b1; // RQ8
                end
            end else if (reg_addr == `REG_STATUS) begin
                if (reg_wdata[`ST_PARAM_BIT]) begin
                    nxt_r.param_err = 1'b0;
                end
                if (reg_wdata[`ST_DEFER_BIT]) begin
                    nxt_r.defer_err = 1'b0;
                end
            end
        end
        case (r_ff.st)
            S_IDLE: begin
                if (cmd_valid) begin
                    nxt_r.cmd   = cmd;
                    nxt_r.early = 1'b0;
                    nxt_r.st    = S_LOOK;
                end
            end
            S_LOOK: begin
                if (r_ff.cmd.op == OP_READ) begin
                    if (hit) begin
                        nxt_r.resp_valid  = 1'b1; // RQ4
                        nxt_r.resp        = '{good: 1'b1, hit: 1'b1, pf_hit: hit_pf};
                        nxt_r.pf_on       = hit_pf ? 1'b1 : r_ff.pf_on; // RQ17
                        nxt_r.hits        = r_ff.hits + 16'(!hit_pf);
                        nxt_r.pf_hits     = r_ff.pf_hits + 16'(hit_pf);
                        nxt_r.last_end    = 32'(req_end);
                        nxt_r.st          = S_IDLE;
                    end else begin
                        // Read-ahead follows sequential streams only.
                        nxt_r.pf_on = r_ff.cmd.lba == r_ff.last_end; // RQ17
                        nxt_r.ext   = (!r_ff.read_ahead_disable_flag && nxt_r.pf_on) ? 16'(PF_BLKS) : 16'h0; // RQ14 RQ15 RQ16
                        nxt_r.st    = S_INVAL; // RQ5
                    end
                end else if (r_ff.cmd.op == OP_WRITE) begin
                    nxt_r.ext = 16'h0;
                    for (int i = 0; i < `SEG_NUM; i++) begin
                        if (!r_ff.seg[i].dirty && r_ff.cmd.lba < {r_ff.seg[i].start} + 32'(r_ff.seg[i].cnt)
                            && 33'(r_ff.seg[i].start) < req_end) begin
                            nxt_r.seg[i].valid = 1'b0; // RQ10
                        end
                    end
                    nxt_r.st = S_INVAL;
                end else begin
                    // Writes finish before a new command is taken, so nothing is left dirty.
                    nxt_r.resp_valid = 1'b1; // RQ13
                    nxt_r.resp       = '{good: 1'b1, hit: 1'b0, pf_hit: 1'b0};
                    nxt_r.st         = S_IDLE;
                end
            end
            S_INVAL: begin
                // Victims are never dirty, so uncommitted data is not overwritten.
                nxt_r.cur                = vict; // RQ6 RQ11
                nxt_r.vptr               = vict + `SEG_IDX_W'(1);
                nxt_r.seg[vict].valid    = 1'b0;
                nxt_r.seg[vict].pf       = r_ff.ext != 16'h0;
                nxt_r.seg[vict].pfb      = r_ff.cmd.lba + 32'(r_ff.cmd.nblk);
                nxt_r.seg[vict].dirty    = r_ff.cmd.op == OP_WRITE;
                // Longer transfers wrap; the segment keeps the final blocks.
                nxt_r.seg[vict].cnt      = (tot > 17'(cap)) ? cap : 16'(tot); // RQ11
                nxt_r.seg[vict].start    = 32'(tot_end) - 32'(nxt_r.seg[vict].cnt);
                nxt_r.med_valid          = 1'b1; // RQ20
                nxt_r.med                = '{write: r_ff.cmd.op == OP_WRITE, lba: r_ff.cmd.lba,
                                             nblk: 16'(tot), seg: vict};
                if (r_ff.cmd.op == OP_WRITE && r_ff.write_cache_enable_flag) begin
                    nxt_r.early      = 1'b1; // RQ12
                    nxt_r.resp_valid = 1'b1;
                    nxt_r.resp       = '{good: 1'b1, hit: 1'b0, pf_hit: 1'b0};
                end
                nxt_r.st = S_MREQ;
            end
            S_MREQ: begin
                if (med_ready) begin
                    nxt_r.med_valid = 1'b0;
                    nxt_r.st        = S_MWAIT;
                end
            end
            default: begin
                if (med_done) begin
                    nxt_r.seg[r_ff.cur].dirty = 1'b0;
                    nxt_r.seg[r_ff.cur].valid = !med_err
                        && (!r_ff.read_cache_disable_flag || r_ff.seg[r_ff.cur].pf); // RQ3 RQ9 RQ14
                    if (r_ff.cmd.op == OP_READ) begin
                        nxt_r.last_end = 32'(req_end);
                    end
                    if (r_ff.early) begin
                        nxt_r.defer_err = r_ff.defer_err | med_err; // RQ12
                    end else begin
                        nxt_r.resp_valid = 1'b1; // RQ5
                        nxt_r.resp       = '{good: !med_err, hit: 1'b0, pf_hit: 1'b0};
                    end
                    nxt_r.st = S_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            r_ff        <= '0;
            r_ff.st     <= S_IDLE;
            r_ff.read_cache_disable_flag    <= `RST_RCD;
            r_ff.write_cache_enable_flag    <= `RST_WCE;
            r_ff.read_ahead_disable_flag    <= `RST_DRA;
            r_ff.param_check_flag_a <= `RST_PARAM_CHECK_FLAG_A;
            r_ff.bsz    <= `RST_BSZ;
        end else if (ce) begin
            r_ff <= nxt_r;
        end
    end

    assign reg_rdata  = r_ff.rdata;
    assign resp_valid = r_ff.resp_valid;
    assign resp       = r_ff.resp;
    assign med_valid  = r_ff.med_valid;
    assign med        = r_ff.med;

    property p_hit_nomedia;
        @(posedge clk) disable iff (rst)
        resp_valid && resp.hit |-> !med_valid && $past(r_ff.st) == S_LOOK;
    endproperty
    a_hit_nomedia: assert property (p_hit_nomedia) else $error("Hit answered with media access."); // RQ4

    property p_segsize;
        @(posedge clk) disable iff (rst)
        ce && reg_rd && reg_addr == `REG_SEGSIZE |=> reg_rdata == 32'h0000FFFF;
    endproperty
    a_segsize: assert property (p_segsize) else $error("Segment size read not 0xFFFF."); // RQ7

    property p_param_check_flag_a;
        @(posedge clk) disable iff (rst)
        ce && reg_wr && reg_addr == `REG_SEGSIZE && r_ff.param_check_flag_a |=> r_ff.param_err;
    endproperty
    a_param_check_flag_a: assert property (p_param_check_flag_a) else $error("Param_check_flag_a size write not flagged."); // RQ8

    property p_victim_clean;
        @(posedge clk) disable iff (rst)
        r_ff.st == S_INVAL |-> !r_ff.seg[vict].dirty;
    endproperty
    a_victim_clean: assert property (p_victim_clean) else $error("Dirty segment reused."); // RQ11

    property p_med_after_lookup;
        @(posedge clk) disable iff (rst)
        $rose(med_valid) |-> $past(r_ff.st) == S_INVAL;
    endproperty
    a_med_after_lookup: assert property (p_med_after_lookup) else $error("Media before lookup."); // RQ20

    property p_med_hold;
        @(posedge clk) disable iff (rst)
        med_valid && !(ce && med_ready) |=> med_valid && $stable(med);
    endproperty
    a_med_hold: assert property (p_med_hold) else $error("Media request dropped."); // RQ5

    property p_deferred;
        @(posedge clk) disable iff (rst)
        ce && r_ff.st == S_MWAIT && r_ff.early && med_done && med_err |=> r_ff.defer_err;
    endproperty
    a_deferred: assert property (p_deferred) else $error("Deferred error lost."); // RQ12

    property p_sync_clean;
        @(posedge clk) disable iff (rst)
        ce && r_ff.st == S_LOOK && r_ff.cmd.op == OP_SYNC |-> r_ff.seg[0].dirty == 1'b0
            && r_ff.seg[r_ff.cur].dirty == 1'b0;
    endproperty
    a_sync_clean: assert property (p_sync_clean) else $error("Sync with dirty data."); // RQ13

    property p_no_pf_when_disabled;
        @(posedge clk) disable iff (rst)
        $rose(med_valid) && r_ff.read_ahead_disable_flag |-> med.nblk == r_ff.cmd.nblk;
    endproperty
    a_no_pf_when_disabled: assert property (p_no_pf_when_disabled) else $error("Read-ahead while disabled."); // RQ15

    property p_rcd_no_lookup;
        @(posedge clk) disable iff (rst)
        resp_valid && resp.hit && !resp.pf_hit |-> !$past(r_ff.read_cache_disable_flag);
    endproperty
    a_rcd_no_lookup: assert property (p_rcd_no_lookup) else $error("Cache hit with cache disabled."); // RQ3
endmodule : seg_cache
`default_nettype wire

// ---- seg_media_model.sv ----
// Behavioural media path that answers the cache controller's requests.
`timescale 1ns/1ps
`default_nettype none
module seg_media_model
    import seg_cache_pkg::*;
(
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        rst,
    // Request from the controller.
    input  wire logic        med_valid,
    input  wire med_s        med,
    output logic             med_ready,
    output logic             med_done,
    output logic             med_err,
    // Test controls and observation.
    input  wire logic        slow,
    input  wire logic        err_inject,
    output logic      [31:0] req_cnt,
    output med_s             last_med
);
    logic       busy_ff;
    logic [5:0] cnt_ff;
    logic [2:0] stall_ff;

    // A slow medium holds ready low for a few cycles of each request.
    assign med_ready = !busy_ff && (!slow || stall_ff == 3'h0);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busy_ff  <= 1'b0;
            cnt_ff   <= 6'h0;
            stall_ff <= 3'h5;
            med_done <= 1'b0;
            med_err  <= 1'b0;
            req_cnt  <= 32'h0;
            last_med <= '0;
        end else begin
            med_done <= 1'b0;
            // The error line carries no meaning outside a done pulse.
            med_err  <= ~med_err;
            if (med_valid && !busy_ff && stall_ff != 3'h0) begin
                stall_ff <= stall_ff - 3'h1;
            end
            if (med_valid && med_ready) begin
                busy_ff  <= 1'b1;
                cnt_ff   <= slow ? 6'h14 : 6'h2;
                stall_ff <= 3'h5;
                req_cnt  <= req_cnt + 32'h1;
                last_med <= med;
            end else if (busy_ff) begin
                cnt_ff <= cnt_ff - 6'h1;
                if (cnt_ff == 6'h1) begin
                    busy_ff  <= 1'b0;
                    med_done <= 1'b1;
                    med_err  <= err_inject;
                end
            end
        end
    end
endmodule : seg_media_model
`default_nettype wire

// ---- seg_cache_bench.sv ----
// Self-checking testbench for the segmented cache controller.
`timescale 1ns/1ps
`default_nettype none
`include "seg_cache_defines.svh"
module seg_cache_bench;
    import seg_cache_pkg::*;
    localparam int PF = 4;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic        cmd_valid = 1'b0;
    cmd_s        cmd = '0;
    logic        cmd_ready;
    logic        resp_valid;
    resp_s       resp;
    logic        med_valid;
    med_s        med;
    logic        med_ready;
    logic        med_done;
    logic        med_err;
    logic        ce = 1'b1;
    logic        slow = 1'b0;
    logic        err_inject = 1'b0;
    logic [31:0] req_cnt;
    med_s        last_med;
    int          fail_count = 0;
    int          checks = 0;
    resp_s       r;
    int          lat;
    logic [31:0] rd;
    logic [31:0] n0;

    always #2.5 clk = ~clk;

    seg_cache #(.PF_BLKS(PF)) u_dut (
        .clk(clk), .rst(rst), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmd_valid(cmd_valid),
        .cmd(cmd), .cmd_ready(cmd_ready), .resp_valid(resp_valid), .resp(resp),
        .med_valid(med_valid), .med(med), .med_ready(med_ready), .med_done(med_done),
        .med_err(med_err));

    seg_media_model u_med (
        .clk(clk), .rst(rst), .med_valid(med_valid), .med(med), .med_ready(med_ready),
        .med_done(med_done), .med_err(med_err), .slow(slow), .err_inject(err_inject),
        .req_cnt(req_cnt), .last_med(last_med));

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : reg_read

    task automatic do_cmd(input cmd_op_e op, input logic [31:0] lba, input logic [15:0] nb);
        int k;
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd       <= '{op: op, lba: lba, nblk: nb};
        k = 0;
        @(negedge clk);
        while (cmd_ready !== 1'b1 && k < 2000) begin
            @(negedge clk);
            k++;
        end
        @(posedge clk);
        cmd_valid <= 1'b0;
        lat = 0;
        do begin
            @(posedge clk);
            #1;
            lat++;
        end while (resp_valid !== 1'b1 && lat < 2000);
        r = resp;
        chk("resp_valid", 32'h1, {31'h0, resp_valid});
    endtask : do_cmd

    task automatic print_verdict;
        if (fail_count == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : print_verdict

    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        print_verdict();
    end

    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        reg_read(`REG_MODE, rd);
        chk("mode reset", 32'h2, rd);
        reg_read(8'h10, rd);
        chk("unmapped", 32'h0, rd);
        reg_write(`REG_SEGSIZE, 32'h1234);
        reg_read(`REG_SEGSIZE, rd);
        chk("segsize", 32'hFFFF, rd);
        reg_read(`REG_STATUS, rd);
        chk("param lax", 32'h0, rd & 32'h1);
        reg_write(`REG_MODE, 32'h0A);
        reg_write(`REG_SEGSIZE, 32'h0040);
        reg_read(`REG_STATUS, rd);
        chk("param param_check_flag_a", 32'h1, rd & 32'h1);
        for (int b = 0; b < 4; b++) begin
            reg_write(`REG_MODE, 32'(b) << 4);
            reg_read(`REG_MODE, rd);
            chk("blk size", (b == 3) ? 32'h20 : 32'(b) << 4, rd);
        end
        reg_write(`REG_MODE, 32'h0);
        do_cmd(OP_WRITE, 32'd100, 16'd4);
        chk("wr media", 32'h00010064, 32'({last_med.write, last_med.lba[15:0]}));
        chk("wr nblk", 32'd4, 32'(last_med.nblk));
        chk("wr good", 32'h1, {31'h0, r.good});
        n0 = req_cnt;
        do_cmd(OP_READ, 32'd100, 16'd4);
        chk("read hit", 32'h3, {30'h0, r.hit, r.good});
        chk("hit lat", 32'd1, 32'(lat));
        chk("hit no media", n0, req_cnt);
        do_cmd(OP_WRITE, 32'd102, 16'd1);
        n0 = req_cnt;
        do_cmd(OP_READ, 32'd100, 16'd4);
        chk("inval miss", 32'h0, {31'h0, r.hit});
        chk("miss media", n0 + 32'h1, req_cnt);
        chk("miss lba", 32'd100, last_med.lba);
        do_cmd(OP_READ, 32'd200, 16'd4);
        do_cmd(OP_READ, 32'd204, 16'd4);
        chk("pf nblk", 32'd4 + PF, 32'(last_med.nblk));
        n0 = req_cnt;
        do_cmd(OP_READ, 32'd208, 16'd2);
        chk("pf hit", 32'h1, {31'h0, r.pf_hit});
        chk("pf no media", n0, req_cnt);
        reg_read(`REG_STATUS, rd);
        chk("pf on", 32'h8, rd & 32'h8);
        reg_read(`REG_HITS, rd);
        chk("hit count", 32'h00010001, rd);
        reg_write(`REG_MODE, 32'h4);
        do_cmd(OP_READ, 32'd500, 16'd2);
        do_cmd(OP_READ, 32'd502, 16'd2);
        chk("dra nblk", 32'd2, 32'(last_med.nblk));
        reg_write(`REG_MODE, 32'h1);
        do_cmd(OP_WRITE, 32'd300, 16'd2);
        n0 = req_cnt;
        do_cmd(OP_READ, 32'd300, 16'd2);
        chk("rcd miss", 32'h0, {31'h0, r.hit});
        chk("rcd media", n0 + 32'h1, req_cnt);
        reg_write(`REG_MODE, 32'h2);
        slow       <= 1'b1;
        err_inject <= 1'b1;
        n0 = req_cnt;
        do_cmd(OP_WRITE, 32'd400, 16'd2);
        chk("early good", 32'h1, {31'h0, r.good});
        chk("early lat", 32'd2, 32'(lat));
        do_cmd(OP_SYNC, 32'd0, 16'd0);
        chk("sync good", 32'h1, {31'h0, r.good});
        chk("sync after media", n0 + 32'h1, req_cnt);
        chk("sync no busy", 32'h0, {31'h0, u_med.busy_ff});
        err_inject <= 1'b0;
        slow       <= 1'b0;
        reg_read(`REG_STATUS, rd);
        chk("deferred", 32'h2, rd & 32'h2);
        reg_write(`REG_STATUS, 32'h2);
        reg_read(`REG_STATUS, rd);
        chk("deferred clr", 32'h0, rd & 32'h2);
        @(posedge clk);
        ce <= 1'b0;
        reg_write(`REG_MODE, 32'h3F);
        ce <= 1'b1;
        reg_read(`REG_MODE, rd);
        chk("ce freeze", 32'h2, rd);
        reg_read(`REG_SEGSIZE, rd);
        chk("segsize keep", 32'hFFFF, rd);
        print_verdict();
    end
endmodule : seg_cache_bench
`default_nettype wire
